//--- hw/flash_bridge_pkg.sv
package flash_bridge_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 40;
  localparam int SCK_DIV       = (SCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_FALL  = 2'h3;

  // ==========================================================================
  // Configuration space
  localparam logic [15:0] CFG_INDEX_PORT  = 16'h002e;
  localparam logic [15:0] CFG_DATA_PORT   = 16'h002f;
  localparam logic [7:0]  CFG_STRAP_IDX   = 8'h24;
  localparam logic [7:0]  CFG_BASE_HI_IDX = 8'h62;
  localparam logic [7:0]  CFG_BASE_LO_IDX = 8'h63;
  localparam int          STRAP_BIT       = 1;
  localparam logic [7:0]  BASE_HI_RESET   = 8'h00;
  localparam logic [7:0]  BASE_LO_RESET   = 8'h00;
  localparam logic [15:0] WINDOW_SPAN     = 16'h0008;

  // ==========================================================================
  // Command window offsets
  localparam logic [2:0] OFF_OPCODE   = 3'h0;
  localparam logic [2:0] OFF_MODE     = 3'h1;
  localparam logic [2:0] OFF_ADDR_MID = 3'h2;
  localparam logic [2:0] OFF_ADDR_LOW = 3'h3;

  // ==========================================================================
  // Flash command shapes
  localparam logic [3:0] MODE_PARAM      = 4'h2;
  localparam logic [3:0] MODE_DUMMY_READ = 4'h7;
  localparam logic [3:0] MODE_READ_ONE   = 4'h8;
  localparam logic [7:0] MEM_READ_OP     = 8'h03;
  localparam logic [7:0] DUMMY_BYTE      = 8'h00;
  localparam logic [7:0] NO_DATA         = 8'hff;

  // ==========================================================================
  // LPC nibble codes
  localparam logic [3:0] LAD_START  = 4'h0;
  localparam logic [3:0] CYC_IO_RD  = 4'h0;
  localparam logic [3:0] CYC_IO_WR  = 4'h2;
  localparam logic [3:0] CYC_MEM_RD = 4'h4;
  localparam logic [3:0] SYNC_LONG  = 4'h6;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] LAD_IDLE   = 4'hf;

  typedef enum logic [1:0] {
    K_WIN      = 2'b00,
    K_CFG_IDX  = 2'b01,
    K_CFG_DATA = 2'b10,
    K_MEM      = 2'b11
  } req_kind_e;

  typedef struct packed {
    req_kind_e   kind;
    logic        write;
    logic [2:0]  off;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } lpc_req_s;

  typedef struct packed {
    logic [7:0]  rdata;
    logic [15:0] base;
  } lpc_ans_s;

  typedef struct packed {
    logic [3:0] n_tx;
    logic [2:0] n_rx;
  } shape_s;

  // Bytes sent and received per mode; zero bytes marks an unused code
  function automatic shape_s mode_shape(input logic [3:0] m);
    case (m)
      4'h1:    mode_shape = '{n_tx: 4'h1, n_rx: 3'h0};
      4'h2:    mode_shape = '{n_tx: 4'h2, n_rx: 3'h0};
      4'h3:    mode_shape = '{n_tx: 4'h1, n_rx: 3'h2};
      4'h4:    mode_shape = '{n_tx: 4'h4, n_rx: 3'h0};
      4'h5:    mode_shape = '{n_tx: 4'h5, n_rx: 3'h0};
      4'h6:    mode_shape = '{n_tx: 4'h8, n_rx: 3'h0};
      4'h7:    mode_shape = '{n_tx: 4'h5, n_rx: 3'h4};
      4'h8:    mode_shape = '{n_tx: 4'h4, n_rx: 3'h1};
      4'h9:    mode_shape = '{n_tx: 4'h4, n_rx: 3'h2};
      4'ha:    mode_shape = '{n_tx: 4'h4, n_rx: 3'h3};
      4'hb:    mode_shape = '{n_tx: 4'h4, n_rx: 3'h4};
      default: mode_shape = '{n_tx: 4'h0, n_rx: 3'h0};
    endcase
  endfunction : mode_shape

endpackage : flash_bridge_pkg

//--- hw/lpc_spi_flash_command_bridge.sv
`timescale 1ns/1ps
`default_nettype none

module lpc_spi_flash_command_bridge (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Power-up strap
  input  wire logic       spi_strap,
  // LPC link
  input  wire logic       lpc_clk,
  input  wire logic       lframe_n,
  input  wire logic [3:0] lad_in,
  output logic      [3:0] lad_out,
  output logic            lad_oe,
  // Serial flash
  output logic            spi_sck,
  output logic            spi_mosi,
  output logic            flash_select_n,
  input  wire logic       spi_miso
);
  import flash_bridge_pkg::*;

  // ==========================================================================
  // LPC domain
  typedef enum logic [2:0] {
    L_IDLE   = 3'b000,
    L_CYC    = 3'b001,
    L_ADDR   = 3'b010,
    L_WDATA  = 3'b011,
    L_TAR    = 3'b100,
    L_SYNC   = 3'b101,
    L_RDATA  = 3'b110,
    L_TAROUT = 3'b111
  } l_state_e;

  logic [1:0]  rst_l_q;
  logic        lpc_rst;
  logic        strap_l_meta_q, strap_l_sync_q, strap_l_q, strap_l_done_q;
  logic        ack_meta_q, ack_sync_q;
  l_state_e    l_state_q;
  logic [2:0]  nib_q;
  logic        cyc_write_q, cyc_mem_q, issued_q;
  logic [31:0] addr_q;
  logic [7:0]  wdata_q, rdata_q;
  logic [15:0] base_copy_q, win_diff;
  logic [3:0]  lad_out_q;
  logic        lad_oe_q, req_tgl_q, pending, claim;
  lpc_req_s    req_q, built;
  lpc_ans_s    ans_q;
  logic        ack_tgl_q;

  // Reset release is brought into the link clock before it is used there
  always_ff @(posedge lpc_clk) begin
    rst_l_q <= {rst_l_q[0], sys_rst};
  end
  assign lpc_rst = rst_l_q[1];

  // Each domain catches the strap itself so decode never waits on the other
  always_ff @(posedge lpc_clk) begin
    strap_l_meta_q <= spi_strap;
    strap_l_sync_q <= strap_l_meta_q;
    if (lpc_rst) begin
      strap_l_q      <= 1'b0;
      strap_l_done_q <= 1'b0;
    end else if (!strap_l_done_q) begin
      strap_l_q      <= strap_l_sync_q;
      strap_l_done_q <= 1'b1;
    end
  end

  always_ff @(posedge lpc_clk) begin
    ack_meta_q <= ack_tgl_q;
    ack_sync_q <= ack_meta_q;
  end
  assign pending  = req_tgl_q != ack_sync_q;
  assign win_diff = addr_q[15:0] - base_copy_q;

  always_comb begin
    claim       = 1'b0;
    built       = '0;
    built.kind  = K_MEM;
    built.write = cyc_write_q;
    built.off   = win_diff[2:0];
    built.addr  = addr_q[23:0];
    built.wdata = wdata_q;
    if (cyc_mem_q) begin
      claim = strap_l_q;
    end else if (addr_q[15:0] == CFG_INDEX_PORT) begin
      claim      = 1'b1;
      built.kind = K_CFG_IDX;
    end else if (addr_q[15:0] == CFG_DATA_PORT) begin
      claim      = 1'b1;
      built.kind = K_CFG_DATA;
    end else if (strap_l_q && win_diff < WINDOW_SPAN) begin
      claim      = 1'b1;
      built.kind = K_WIN;
    end
  end

  always_ff @(posedge lpc_clk) begin
    if (lpc_rst) begin
      l_state_q   <= L_IDLE;
      nib_q       <= 3'h0;
      cyc_write_q <= 1'b0;
      cyc_mem_q   <= 1'b0;
      issued_q    <= 1'b0;
      addr_q      <= 32'h0;
      wdata_q     <= 8'h00;
      rdata_q     <= 8'h00;
      base_copy_q <= {BASE_HI_RESET, BASE_LO_RESET};
      lad_out_q   <= LAD_IDLE;
      lad_oe_q    <= 1'b0;
      req_tgl_q   <= 1'b0;
      req_q       <= '0;
    end else if (!lframe_n && lad_in == LAD_START) begin
      // A new start frame aborts whatever cycle was in progress
      l_state_q <= L_CYC;
      lad_oe_q  <= 1'b0;
    end else begin
      unique case (l_state_q)
        L_IDLE: begin
          lad_oe_q <= 1'b0;
        end
        L_CYC: begin
          cyc_write_q <= lad_in == CYC_IO_WR;
          cyc_mem_q   <= lad_in == CYC_MEM_RD;
          nib_q       <= (lad_in == CYC_MEM_RD) ? 3'h7 : 3'h3;
          if (lad_in == CYC_IO_RD || lad_in == CYC_IO_WR || lad_in == CYC_MEM_RD) begin
            l_state_q <= L_ADDR;
          end else begin
            l_state_q <= L_IDLE;
          end
        end
        L_ADDR: begin
          addr_q <= {addr_q[27:0], lad_in};
          nib_q  <= nib_q - 3'h1;
          if (nib_q == 3'h0) begin
            nib_q     <= 3'h1;
            l_state_q <= cyc_write_q ? L_WDATA : L_TAR;
          end
        end
        L_WDATA: begin
          wdata_q <= {lad_in, wdata_q[7:4]};
          nib_q   <= nib_q - 3'h1;
          if (nib_q == 3'h0) begin
            nib_q     <= 3'h1;
            l_state_q <= L_TAR;
          end
        end
        L_TAR: begin
          nib_q <= nib_q - 3'h1;
          if (nib_q == 3'h0) begin
            issued_q <= 1'b0;
            if (claim) begin
              l_state_q <= L_SYNC;
              lad_oe_q  <= 1'b1;
              lad_out_q <= SYNC_LONG;
            end else begin
              l_state_q <= L_IDLE;
            end
          end
        end
        L_SYNC: begin
          // Request words only change while no handshake is outstanding
          if (!issued_q) begin
            if (!pending) begin
              req_q     <= built;
              req_tgl_q <= ~req_tgl_q;
              issued_q  <= 1'b1;
            end
          end else if (!pending) begin
            rdata_q     <= ans_q.rdata;
            base_copy_q <= ans_q.base;
            lad_out_q   <= SYNC_READY;
            nib_q       <= 3'h0;
            l_state_q   <= cyc_write_q ? L_TAROUT : L_RDATA;
          end
        end
        L_RDATA: begin
          nib_q     <= nib_q + 3'h1;
          lad_out_q <= (nib_q == 3'h0) ? rdata_q[3:0] : rdata_q[7:4];
          if (nib_q != 3'h0) begin
            nib_q     <= 3'h0;
            l_state_q <= L_TAROUT;
          end
        end
        L_TAROUT: begin
          nib_q     <= 3'h1;
          lad_out_q <= LAD_IDLE;
          if (nib_q != 3'h0) begin
            lad_oe_q  <= 1'b0;
            l_state_q <= L_IDLE;
          end
        end
      endcase
    end
  end

  assign lad_out = lad_out_q;
  assign lad_oe  = lad_oe_q;

  // ==========================================================================
  // System domain: handshake and registers
  typedef enum logic [1:0] {
    E_IDLE  = 2'b00,
    E_SHIFT = 2'b01,
    E_END   = 2'b10
  } e_state_e;

  logic        strap_meta_q, strap_sync_q, strap_q, strap_done_q;
  logic        req_meta_q, req_sync_q, req_seen_q;
  logic        miso_meta_q, miso_sync_q;
  logic [7:0]  opcode_q, addr_mid_q, addr_low_q, cfg_index_q, base_hi_q, base_lo_q;
  logic [3:0]  mode_q, addr_top_q;
  logic [7:0]  payload_q [4];
  logic [7:0]  rd_val, base_hi_d, base_lo_d, rx_val, rx_byte_q;
  logic        accept, win_wr, cfg_wr, launch_win, launch_mem, rx_store, rx_phase;
  logic [1:0]  rx_idx;
  e_state_e    e_state_q;
  logic [3:0]  cur_mode_q, byte_q, total_bytes;
  logic [7:0]  cur_op_q, cur_tx;
  logic [23:0] cur_addr_q;
  logic [2:0]  bit_q;
  logic [1:0]  ph_q;
  logic [7:0]  rx_sh_q;
  logic        from_mem_q, sck_q, mosi_q, cs_n_q;
  shape_s      cur_shape, win_shape;

  always_ff @(posedge mclk) begin
    strap_meta_q <= spi_strap;
    strap_sync_q <= strap_meta_q;
    req_meta_q   <= req_tgl_q;
    req_sync_q   <= req_meta_q;
    miso_meta_q  <= spi_miso;
    miso_sync_q  <= miso_meta_q;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q      <= strap_sync_q;
      strap_done_q <= 1'b1;
    end
  end

  // New requests wait while a frame runs, so the host sees long waits
  assign accept     = req_sync_q != req_seen_q && e_state_q == E_IDLE;
  assign win_wr     = accept && req_q.kind == K_WIN && req_q.write && strap_q;
  assign cfg_wr     = accept && req_q.kind == K_CFG_DATA && req_q.write;
  assign win_shape  = mode_shape(req_q.wdata[7:4]);
  assign launch_win = win_wr && req_q.off == OFF_MODE && win_shape.n_tx != 4'h0;
  assign launch_mem = accept && req_q.kind == K_MEM && strap_q;

  always_comb begin
    base_hi_d = base_hi_q;
    base_lo_d = base_lo_q;
    if (cfg_wr && cfg_index_q == CFG_BASE_HI_IDX) base_hi_d = req_q.wdata;
    if (cfg_wr && cfg_index_q == CFG_BASE_LO_IDX) base_lo_d = req_q.wdata;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_index_q <= 8'h00;
      base_hi_q   <= BASE_HI_RESET;
      base_lo_q   <= BASE_LO_RESET;
    end else begin
      base_hi_q <= base_hi_d;
      base_lo_q <= base_lo_d;
      if (accept && req_q.kind == K_CFG_IDX && req_q.write) cfg_index_q <= req_q.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opcode_q   <= 8'h00;
      mode_q     <= 4'h0;
      addr_top_q <= 4'h0;
      addr_mid_q <= 8'h00;
      addr_low_q <= 8'h00;
      for (int i = 0; i < 4; i++) payload_q[i] <= 8'h00;
    end else begin
      if (win_wr) begin
        unique case (req_q.off)
          3'h0: opcode_q <= req_q.wdata;
          3'h1: begin
            mode_q     <= req_q.wdata[7:4];
            addr_top_q <= req_q.wdata[3:0];
          end
          3'h2: addr_mid_q <= req_q.wdata;
          3'h3: addr_low_q <= req_q.wdata;
          3'h4, 3'h5, 3'h6, 3'h7: payload_q[req_q.off[1:0]] <= req_q.wdata;
        endcase
      end
      if (rx_store) payload_q[rx_idx] <= rx_val;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (req_q.kind)
      K_WIN: begin
        unique case (req_q.off)
          3'h0: rd_val = opcode_q;
          3'h1: rd_val = {mode_q, addr_top_q};
          3'h2: rd_val = addr_mid_q;
          3'h3: rd_val = addr_low_q;
          3'h4, 3'h5, 3'h6, 3'h7: rd_val = payload_q[req_q.off[1:0]];
        endcase
      end
      K_CFG_IDX: rd_val = cfg_index_q;
      K_CFG_DATA: begin
        if (cfg_index_q == CFG_STRAP_IDX) rd_val[STRAP_BIT] = strap_q;
        if (cfg_index_q == CFG_BASE_HI_IDX) rd_val = base_hi_q;
        if (cfg_index_q == CFG_BASE_LO_IDX) rd_val = base_lo_q;
      end
      K_MEM: rd_val = NO_DATA;
    endcase
  end

  // Register accesses answer at once; memory reads answer when the frame ends
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
      ans_q      <= '0;
    end else begin
      if (accept) req_seen_q <= req_sync_q;
      if (accept && !launch_mem) begin
        ack_tgl_q  <= req_sync_q;
        ans_q      <= '{rdata: rd_val, base: {base_hi_d, base_lo_d}};
      end
      if (e_state_q == E_END && from_mem_q) begin
        ack_tgl_q  <= req_seen_q;
        ans_q      <= '{rdata: rx_byte_q, base: {base_hi_q, base_lo_q}};
      end
    end
  end

  // ==========================================================================
  // Serial engine
  function automatic logic [7:0] tx_byte(input logic [3:0] m, input logic [3:0] idx, input logic [7:0] op,
                                         input logic [23:0] a, input logic [31:0] pl);
    shape_s s;
    s = mode_shape(m);
    if (idx == 4'h0)                 tx_byte = op;
    else if (idx >= s.n_tx)          tx_byte = DUMMY_BYTE;
    else if (m == MODE_PARAM)        tx_byte = pl[7:0];
    else if (idx <= 4'h3)            tx_byte = a[8'(4'h3 - idx) * 8 +: 8];
    else if (m == MODE_DUMMY_READ)   tx_byte = DUMMY_BYTE;
    else                             tx_byte = pl[8'(idx - 4'h4) * 8 +: 8];
  endfunction : tx_byte

  assign cur_shape   = mode_shape(cur_mode_q);
  assign total_bytes = cur_shape.n_tx + {1'b0, cur_shape.n_rx};
  assign cur_tx      = tx_byte(cur_mode_q, byte_q, cur_op_q, cur_addr_q,
                               {payload_q[3], payload_q[2], payload_q[1], payload_q[0]});
  assign rx_phase    = byte_q >= cur_shape.n_tx;
  assign rx_idx      = 2'(byte_q - cur_shape.n_tx);
  assign rx_val      = {rx_sh_q[6:0], miso_sync_q};
  assign rx_store    = e_state_q == E_SHIFT && ph_q == PH_FALL && bit_q == 3'h7 && rx_phase && !from_mem_q;

  // Clock is divided by four so the two-flop miso path still meets the sample point
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      e_state_q  <= E_IDLE;
      cs_n_q     <= 1'b1;
      sck_q      <= 1'b0;
      mosi_q     <= 1'b0;
      ph_q       <= PH_DRIVE;
      byte_q     <= 4'h0;
      bit_q      <= 3'h0;
      cur_mode_q <= 4'h0;
      cur_op_q   <= 8'h00;
      cur_addr_q <= 24'h0;
      from_mem_q <= 1'b0;
      rx_sh_q    <= 8'h00;
      rx_byte_q  <= 8'h00;
    end else begin
      unique case (e_state_q)
        E_IDLE: begin
          if (launch_win || launch_mem) begin
            e_state_q  <= E_SHIFT;
            cs_n_q     <= 1'b0;
            ph_q       <= PH_DRIVE;
            byte_q     <= 4'h0;
            bit_q      <= 3'h0;
            from_mem_q <= launch_mem;
            cur_mode_q <= launch_mem ? MODE_READ_ONE : req_q.wdata[7:4];
            cur_op_q   <= launch_mem ? MEM_READ_OP : opcode_q;
            cur_addr_q <= launch_mem ? req_q.addr : {4'h0, req_q.wdata[3:0], addr_mid_q, addr_low_q};
          end
        end
        E_SHIFT: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == PH_DRIVE) mosi_q <= cur_tx[3'h7 - bit_q];
          if (ph_q == PH_RISE) sck_q <= 1'b1;
          if (ph_q == PH_FALL) begin
            sck_q <= 1'b0;
            if (rx_phase) rx_sh_q <= rx_val;
            if (rx_phase && bit_q == 3'h7) rx_byte_q <= rx_val;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              byte_q <= byte_q + 4'h1;
              if (byte_q + 4'h1 == total_bytes) e_state_q <= E_END;
            end
          end
        end
        E_END: begin
          cs_n_q    <= 1'b1;
          mosi_q    <= 1'b0;
          e_state_q <= E_IDLE;
        end
        default: e_state_q <= E_IDLE;
      endcase
    end
  end

  assign spi_sck        = sck_q;
  assign spi_mosi       = mosi_q;
  assign flash_select_n = cs_n_q;

  // ==========================================================================
  // Checks
  logic [8:0] cs_low_cnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst || cs_n_q) cs_low_cnt_q <= 9'h0;
    else                   cs_low_cnt_q <= cs_low_cnt_q + 9'h1;
  end

  property p_cs_idle;
    @(posedge mclk) disable iff (sys_rst) (e_state_q == E_IDLE) |-> (cs_n_q && !sck_q);
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("select or clock active while idle");

  property p_strap_gate;
    @(posedge mclk) disable iff (sys_rst) (strap_done_q && !strap_q) |-> cs_n_q;
  endproperty
  a_strap_gate: assert property (p_strap_gate) else $error("flash selected without strap");

  property p_launch;
    @(posedge mclk) disable iff (sys_rst)
      launch_win |=> (!cs_n_q && e_state_q == E_SHIFT && cur_mode_q == $past(req_q.wdata[7:4]));
  endproperty
  a_launch: assert property (p_launch) else $error("mode write did not start a frame");

  property p_bad_mode;
    @(posedge mclk) disable iff (sys_rst)
      (win_wr && req_q.off == OFF_MODE && !launch_win) |=> cs_n_q [*3];
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("unused mode code started a frame");

  property p_frame_len;
    @(posedge mclk) disable iff (sys_rst) $rose(cs_n_q) |-> cs_low_cnt_q == {total_bytes, 5'h0} + 9'h1;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong for mode");

  property p_opcode_msb;
    @(posedge mclk) disable iff (sys_rst)
      (e_state_q == E_SHIFT && byte_q == 4'h0 && bit_q == 3'h0 && ph_q == PH_RISE) |-> mosi_q == cur_op_q[7];
  endproperty
  a_opcode_msb: assert property (p_opcode_msb) else $error("opcode msb not sent first");

  property p_addr_top_zero;
    @(posedge mclk) disable iff (sys_rst)
      (e_state_q == E_SHIFT && !from_mem_q && cur_shape.n_tx >= 4'h4 && cur_mode_q != MODE_PARAM
       && byte_q == 4'h1 && bit_q < 3'h4 && ph_q == PH_RISE) |-> !mosi_q;
  endproperty
  a_addr_top_zero: assert property (p_addr_top_zero) else $error("address bits 23:20 not zero");

  property p_mem_answer;
    @(posedge mclk) disable iff (sys_rst)
      (e_state_q == E_END && from_mem_q) |=> ($changed(ack_tgl_q) && cs_n_q && ans_q.rdata == $past(rx_byte_q));
  endproperty
  a_mem_answer: assert property (p_mem_answer) else $error("memory read answer wrong");

  property p_rx_store;
    @(posedge mclk) disable iff (sys_rst) (rx_store && rx_idx == 2'h0) |=> payload_q[0] == $past(rx_val);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("first received byte not stored");

  property p_decode_miss;
    @(posedge lpc_clk) disable iff (lpc_rst)
      (l_state_q == L_TAR && nib_q == 3'h0 && !claim && lframe_n) |=> (l_state_q == L_IDLE && !lad_oe_q) [*2];
  endproperty
  a_decode_miss: assert property (p_decode_miss) else $error("unclaimed cycle was driven");

endmodule : lpc_spi_flash_command_bridge

`default_nettype wire

//--- bench/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Serial flash stand-in, mode 0
module flash_model (
  // Flash pins
  input  wire logic spi_sck,
  input  wire logic spi_mosi,
  input  wire logic flash_select_n,
  output logic      spi_miso
);
  logic [7:0] cap [0:15];
  int         nbit = 0;
  logic       bad  = 1'b0;
  function automatic logic rep(input int n);
    logic [7:0] b;
    b = 8'h5a ^ 8'(n / 8);
    return b[7 - n % 8];
  endfunction : rep
  // Select falls with the clock low; a rising clock is a capture
  always @(negedge flash_select_n or posedge spi_sck) begin
    if (!spi_sck) begin
      nbit = 0;
    end else begin
      if (flash_select_n) bad = 1'b1;
      cap[nbit / 8][7 - nbit % 8] = spi_mosi;
      nbit = nbit + 1;
    end
  end
  // Released line shows the inverse so a stale bit never looks valid
  always @(negedge spi_sck or posedge flash_select_n)
    spi_miso <= flash_select_n ? (spi_miso !== 1'b1) : rep(nbit);
endmodule : flash_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_bridge_pkg::*;
  logic       mclk = 0, lpc_clk = 0, sys_rst = 1, spi_strap = 1, lframe_n = 1;
  logic [3:0] h = 4'hf, lad_out;
  logic       lad_oe, spi_sck, spi_mosi, flash_select_n, spi_miso;
  logic [7:0] d, e[$];
  wire  [3:0] lad_in = lad_oe ? lad_out : h;
  int         n_mismatch = 0, check_count = 0;
  always #5 mclk = ~mclk;
  initial begin
    #2;
    forever #15 lpc_clk = ~lpc_clk;
  end
  lpc_spi_flash_command_bridge i_lpc_spi_flash_command_bridge (.mclk, .sys_rst, .spi_strap, .lpc_clk,
    .lframe_n, .lad_in, .lad_out, .lad_oe, .spi_sck, .spi_mosi, .flash_select_n, .spi_miso);
  flash_model i_flash_model (.spi_sck, .spi_mosi, .flash_select_n, .spi_miso);
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input string s, input logic [7:0] x, y);
    check_count++;
    if (x !== y) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  // One LPC host cycle; a refused cycle waits out the bound
  task lpc(input logic [3:0] cyc, input logic [31:0] a, input logic [7:0] w, input bit cl,
           output logic [7:0] r);
    int n;
    n = (cyc == CYC_MEM_RD) ? 8 : 4;
    @(posedge lpc_clk);
    lframe_n <= 0;
    h <= LAD_START;
    @(posedge lpc_clk);
    lframe_n <= 1;
    h <= cyc;
    for (int i = n - 1; i >= 0; i--) @(posedge lpc_clk) h <= a[4*i +: 4];
    if (cyc == CYC_IO_WR) begin
      @(posedge lpc_clk) h <= w[3:0];
      @(posedge lpc_clk) h <= w[7:4];
    end
    @(posedge lpc_clk) h <= 4'hf;
    @(posedge lpc_clk);
    n = 0;
    while (!(lad_oe === 1'b1 && lad_out === SYNC_READY) && n < 300) begin
      @(negedge lpc_clk);
      n++;
    end
    chk("claimed", 8'(cl), 8'(n < 300));
    if (cl && n == 300) conclude();
    if (n < 300) begin
      @(negedge lpc_clk) r[3:0] = lad_in;
      @(negedge lpc_clk) r[7:4] = lad_in;
      repeat (3) @(negedge lpc_clk);
    end
  endtask : lpc
  task wr(input logic [15:0] a, input logic [7:0] w);
    lpc(CYC_IO_WR, {16'h0, a}, w, 1, d);
  endtask : wr
  task rd(input logic [15:0] a);
    lpc(CYC_IO_RD, {16'h0, a}, 8'h0, 1, d);
  endtask : rd
  task boot(input logic s);
    @(posedge mclk);
    sys_rst <= 1;
    spi_strap <= s;
    repeat (12) @(posedge mclk);
    sys_rst <= 0;
    repeat (10) @(posedge lpc_clk);
    wr(CFG_INDEX_PORT, CFG_STRAP_IDX);
    rd(CFG_DATA_PORT);
    chk("strap", {6'h0, s, 1'b0}, d);
  endtask : boot
  initial begin
    int nr;
    boot(1);
    wr(CFG_INDEX_PORT, CFG_BASE_HI_IDX);
    wr(CFG_DATA_PORT, 8'h03);
    wr(CFG_INDEX_PORT, CFG_BASE_LO_IDX);
    wr(CFG_DATA_PORT, 8'hf8);
    rd(CFG_DATA_PORT);
    chk("base_low", 8'hf8, d);
    lpc(CYC_IO_RD, 32'h03f0, 8'h0, 0, d);
    lpc(CYC_IO_RD, 32'h0400, 8'h0, 0, d);
    wr(16'h03f8, 8'h9c);
    wr(16'h03fa, 8'h12);
    wr(16'h03fb, 8'h34);
    for (int m = 1; m < 12; m++) begin // command-only mode 1 runs before the program modes
      for (int k = 0; k < 4; k++) wr(16'(16'h03fc + k), 8'(8'h11 * (k + 1)));
      wr(16'h03f9, {m[3:0], 4'h7});
      e = {8'h9c};
      if (m == 2) e.push_back(8'h11);
      if (m > 3) e = {e, 8'h07, 8'h12, 8'h34};
      if (m == 5) e.push_back(8'h11);
      if (m == 6) e = {e, 8'h11, 8'h22, 8'h33, 8'h44};
      if (m == 7) e.push_back(8'h00);
      nr = (m == 3) ? 2 : (m == 7) ? 4 : (m > 7) ? m - 7 : 0;
      for (int j = 0; j < 4; j++) begin
        rd(16'(16'h03fc + j));
        chk("data", j < nr ? 8'h5a ^ 8'(e.size() + j) : 8'(8'h11 * (j + 1)), d);
      end
      chk("bytes", 8'(e.size() + nr), 8'(i_flash_model.nbit / 8));
      for (int j = 0; j < e.size(); j++) chk("sent", e[j], i_flash_model.cap[j]);
    end
    rd(16'h03f8);
    chk("opcode", 8'h9c, d);
    nr = i_flash_model.nbit;
    wr(16'h03f9, 8'hc5);
    rd(16'h03f9);
    chk("mode_field", 8'hc5, d);
    chk("no_frame", 8'(nr), 8'(i_flash_model.nbit));
    lpc(CYC_MEM_RD, 32'h00abcdef, 8'h0, 1, d);
    chk("mem_data", 8'h5a ^ 8'h04, d);
    e = {MEM_READ_OP, 8'hab, 8'hcd, 8'hef};
    for (int j = 0; j < 4; j++) chk("mem_sent", e[j], i_flash_model.cap[j]);
    chk("select", 8'h0, 8'(i_flash_model.bad));
    boot(0);
    lpc(CYC_MEM_RD, 32'h00000010, 8'h0, 0, d);
    lpc(CYC_IO_RD, 32'h00000004, 8'h0, 0, d);
    conclude();
  end
endmodule : testbench
`default_nettype wire
